// *** inc/tls_pkg.sv ***
// Shared constants and types for the trig and line-segment unit
package tls_pkg;

  // Register byte offsets on the bus
  localparam logic [11:0] OFF_OPER = 12'h000;
  localparam logic [11:0] OFF_CTRL = 12'h004;
  localparam logic [11:0] OFF_SRC = 12'h008;
  localparam logic [11:0] OFF_START = 12'h00C;
  localparam logic [11:0] OFF_RESULT = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h014;
  localparam logic [11:0] OFF_TABLE = 12'h800;
  localparam int TABLE_SEL_BIT = 11;
  localparam int TABLE_Y_BIT = 2;

  // Operand register fields
  localparam int OPER_W = 18;
  localparam int OPER_CONST_C = 16;
  localparam int OPER_CONST_S = 17;

  // Control word fields
  localparam int BIT_IN_BCD = 15;
  localparam int BIT_OUT_BCD = 14;
  localparam int BIT_REVERSE = 13;
  localparam int BIT_SIGNED = 11;
  localparam int BIT_WIDE = 10;
  localparam int BIT_FLOAT = 9;
  localparam int CNT_LSB = 0;
  localparam int CNT_MSB = 7;

  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_ERR = 1;
  localparam int ST_EQ = 2;
  localparam int ST_NEG = 3;
  localparam int ST_DONE = 4;

  // Reset values
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;

  // Mode codes and ranges
  localparam logic [15:0] CTRL_COSINE = 16'h0001;
  localparam logic [15:0] TRIG_MAX_BCD = 16'h0900;
  localparam logic [9:0] ANGLE_FULL = 10'h384;
  localparam logic [13:0] FRAC_MAX = 14'h270F;

  // Float conversion points
  localparam logic [7:0] FP_BIAS = 8'h7F;
  localparam logic [7:0] FP_POINT = 8'h96;
  localparam logic [7:0] FP_SAT = 8'h9E;

  // Divider length, one quotient bit per cycle
  localparam logic [5:0] DIV_STEPS = 6'h22;

  typedef logic signed [33:0] tls_num_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SCAN = 3'b001,
    ST_PICK = 3'b010,
    ST_DIV = 3'b011,
    ST_MUL = 3'b100
  } tls_state_e;

  typedef struct packed {
    logic sel;
    logic write;
    logic [11:0] addr;
  } tls_aphase_s;

  typedef struct packed {
    logic done;
    logic negative;
    logic equals;
    logic error_flag;
    logic busy;
  } tls_status_s;

  // Sine times ten thousand, truncated, at whole degrees; last entry pads interpolation
  localparam logic [13:0] SIN_TAB [0:91] = '{
    14'd0, 14'd174, 14'd348, 14'd523, 14'd697, 14'd871, 14'd1045, 14'd1218, 14'd1391, 14'd1564,
    14'd1736, 14'd1908, 14'd2079, 14'd2249, 14'd2419, 14'd2588, 14'd2756, 14'd2923, 14'd3090,
    14'd3255, 14'd3420, 14'd3583, 14'd3746, 14'd3907, 14'd4067, 14'd4226, 14'd4383, 14'd4539,
    14'd4694, 14'd4848, 14'd5000, 14'd5150, 14'd5299, 14'd5446, 14'd5591, 14'd5735, 14'd5877,
    14'd6018, 14'd6156, 14'd6293, 14'd6427, 14'd6560, 14'd6691, 14'd6819, 14'd6946, 14'd7071,
    14'd7193, 14'd7313, 14'd7431, 14'd7547, 14'd7660, 14'd7771, 14'd7880, 14'd7986, 14'd8090,
    14'd8191, 14'd8290, 14'd8386, 14'd8480, 14'd8571, 14'd8660, 14'd8746, 14'd8829, 14'd8910,
    14'd8987, 14'd9063, 14'd9135, 14'd9205, 14'd9271, 14'd9335, 14'd9396, 14'd9455, 14'd9510,
    14'd9563, 14'd9612, 14'd9659, 14'd9702, 14'd9743, 14'd9781, 14'd9816, 14'd9848, 14'd9876,
    14'd9902, 14'd9925, 14'd9945, 14'd9961, 14'd9975, 14'd9986, 14'd9993, 14'd9998, 14'd10000,
    14'd10000
  };

endpackage

// *** hw/tls_unit.sv ***
// Trig and line-segment conversion unit with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Control 0000 gives sine, 0001 cosine, a table address gives conversion.
// - Control bits 7..0 hold the endpoint count minus one.
// - Between two X points output Yn plus slope times source minus Xn.
// - Below first X give first Y; above largest X give its Y.
// - Up to 256 endpoints held in consecutive table words.
// - Bit 15 selects BCD source, bit 14 selects BCD result.
// - Bit 13 converts largest X minus source instead of source.
// - Bit 11 signed, bit 10 picks 32 or 16 bits; unsigned is 16.
// - Bit 9 treats source and result as single-precision float.
// - A 16-bit constant source in 32-bit mode is sign-widened.
// - A constant source in float mode raises the error flag.
// - A constant control value above 0001 raises the error flag.
// - Table X values not ascending raise the error flag.
// - BCD source that is not valid BCD raises the error flag.
// - Trig source must be BCD 0000..0900; otherwise error, else cleared.
// - Equals flag follows a zero result word.
// - Negative flag follows result bit 15.
// - Trig source is BCD tenths of a degree, 0000 to 0900.
// - Trig result is four BCD fraction digits, truncated.
// - Sine 90 and cosine 0 give 9999.
module tls_unit
  import tls_pkg::*;
#(
  parameter int unsigned MAX_POINTS = 256
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic busy,
  output logic error_flag,
  output logic equals_flag,
  output logic negative_flag
);

  if (MAX_POINTS < 2 || MAX_POINTS > 256) begin : g_bad_depth
    $error("MAX_POINTS must lie between 2 and 256");
  end

  function automatic logic bcd_ok(input logic [15:0] w);
    bcd_ok = (w[3:0] <= 4'h9) && (w[7:4] <= 4'h9) && (w[11:8] <= 4'h9) && (w[15:12] <= 4'h9);
  endfunction

  function automatic logic [13:0] bcd2bin(input logic [15:0] w);
    bcd2bin = 14'(w[15:12]) * 14'h3E8 + 14'(w[11:8]) * 14'h064 + 14'(w[7:4]) * 14'h00A
      + 14'(w[3:0]);
  endfunction

  function automatic logic [15:0] bin2bcd(input logic [13:0] v);
    logic [29:0] sh;
    sh = {16'h0000, v};
    for (int i = 0; i < 14; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (sh[14 + 4 * d +: 4] >= 4'h5) begin
          sh[14 + 4 * d +: 4] = sh[14 + 4 * d +: 4] + 4'h3;
        end
      end
      sh = {sh[28:0], 1'b0};
    end
    bin2bcd = sh[29:14];
  endfunction

  // Angle in tenths of a degree; linear between whole degrees, then truncated
  function automatic logic [13:0] sine(input logic [9:0] a);
    logic [6:0] d;
    logic [3:0] f;
    logic [13:0] lo;
    logic [13:0] hi;
    logic [17:0] acc;
    logic [13:0] v;
    d = 7'(a / 10'h00A);
    f = 4'(a % 10'h00A);
    lo = SIN_TAB[d];
    hi = SIN_TAB[d + 7'h01];
    acc = 18'(lo) * 18'h0000A + 18'(hi - lo) * 18'(f);
    v = 14'(acc / 18'h0000A);
    sine = (v > FRAC_MAX) ? FRAC_MAX : v;
  endfunction

  // Float to integer truncates toward zero and saturates to a magnitude of 7FFFFFFF for either sign
  function automatic tls_num_t f2i(input logic [31:0] f);
    logic [7:0] e;
    logic [31:0] mag;
    e = f[30:23];
    mag = 32'h0000_0000;
    if (e >= FP_SAT) begin
      mag = 32'h7FFF_FFFF;
    end else if (e >= FP_POINT) begin
      mag = {8'h00, 1'b1, f[22:0]} << (e - FP_POINT);
    end else if (e >= FP_BIAS) begin
      mag = {8'h00, 1'b1, f[22:0]} >> (FP_POINT - e);
    end
    f2i = f[31] ? -tls_num_t'({2'b00, mag}) : tls_num_t'({2'b00, mag});
  endfunction

  function automatic logic [31:0] i2f(input logic [31:0] v);
    logic [31:0] m;
    logic [4:0] p;
    logic [31:0] sh;
    m = v[31] ? -v : v;
    p = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (m[i]) begin
        p = 5'(i);
      end
    end
    sh = m << (5'h1F - p);
    i2f = (m == 32'h0000_0000) ? 32'h0000_0000 : {v[31], FP_BIAS + {3'h0, p}, sh[30:8]};
  endfunction

  // Width and sign of an operand word
  function automatic tls_num_t norm(input logic [31:0] w, input logic [15:0] cw);
    if (cw[BIT_FLOAT]) begin
      norm = f2i(w);
    end else if (cw[BIT_SIGNED] && cw[BIT_WIDE]) begin
      norm = {{2{w[31]}}, w};
    end else if (cw[BIT_SIGNED]) begin
      norm = {{18{w[15]}}, w[15:0]};
    end else begin
      norm = {18'h00000, w[15:0]};
    end
  endfunction

  function automatic logic [31:0] fmt(input tls_num_t v, input logic [15:0] cw);
    if (cw[BIT_FLOAT]) begin
      fmt = i2f(v[31:0]);
    end else if (cw[BIT_OUT_BCD]) begin
      // BCD result, clamped to four digits
      if (v < 0) begin
        fmt = 32'h0000_0000;
      end else if (v > tls_num_t'({20'h00000, FRAC_MAX})) begin
        fmt = {16'h0000, bin2bcd(FRAC_MAX)};
      end else begin
        fmt = {16'h0000, bin2bcd(v[13:0])};
      end
    end else if (cw[BIT_SIGNED] && cw[BIT_WIDE]) begin
      fmt = v[31:0];
    end else begin
      fmt = {16'h0000, v[15:0]};
    end
  endfunction

  tls_aphase_s ap;
  tls_state_e state;
  tls_state_e next_state;
  logic [OPER_W-1:0] oper_reg;
  logic [15:0] ctrl_reg;
  logic [31:0] src_reg;
  logic [31:0] result_reg;
  logic err_reg;
  logic done_reg;
  logic [31:0] x_mem [MAX_POINTS];
  logic [31:0] y_mem [MAX_POINTS];
  logic [15:0] cw_q;
  tls_num_t s_eff_q;
  logic [7:0] idx_q;
  logic [7:0] seg_q;
  logic hit_q;
  logic span_q;
  logic order_bad_q;
  logic [33:0] rem_q;
  logic [33:0] quo_q;
  logic [33:0] dvs_q;
  logic qneg_q;
  logic [5:0] dcnt_q;
  logic wr;
  logic idle;
  logic start_go;
  logic [15:0] cw_now;
  logic [7:0] cnt_now;
  tls_num_t s_in;
  tls_num_t s_eff_now;
  logic trig_bad;
  logic start_bad;
  logic [31:0] trig_word;
  logic [13:0] angle_bin;
  tls_num_t xp;
  tls_num_t xc;
  tls_num_t x0;
  tls_num_t xs;
  tls_num_t xs1;
  tls_num_t ys;
  tls_num_t ys1;
  tls_num_t yend;
  tls_num_t q;
  tls_num_t interp;
  tls_num_t dy;
  logic [33:0] rem_sh;
  logic fin;
  logic fin_err;
  logic [31:0] fin_word;
  logic ld_div;
  logic [31:0] rd_word;
  logic [7:0] rd_idx;
  tls_status_s status;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr = ap.sel && ap.write;
  assign idle = (state == ST_IDLE);
  assign start_go = wr && idle && (ap.addr == OFF_START);
  assign busy = !idle;
  assign error_flag = err_reg;
  assign equals_flag = (result_reg == 32'h0000_0000);
  // Bit 15 of the result word; the sign only for 16-bit results
  assign negative_flag = result_reg[15];
  assign status = '{done: done_reg, negative: negative_flag, equals: equals_flag,
                    error_flag: err_reg, busy: busy};

  // Bus address phase; zero wait states, so every address phase is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap <= '0;
    end else if (hready) begin
      ap.sel <= hsel && htrans[1];
      ap.write <= hwrite;
      ap.addr <= haddr[11:0];
    end
  end

  assign rd_idx = haddr[10:3];

  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[11:0])
      OFF_OPER: rd_word = {{(32 - OPER_W){1'b0}}, oper_reg};
      OFF_CTRL: rd_word = {16'h0000, ctrl_reg};
      OFF_SRC: rd_word = src_reg;
      OFF_RESULT: rd_word = result_reg;
      OFF_STATUS: rd_word = {27'h0000000, status};
      default: begin
        if (haddr[TABLE_SEL_BIT] && (32'(rd_idx) < MAX_POINTS)) begin
          rd_word = haddr[TABLE_Y_BIT] ? y_mem[rd_idx] : x_mem[rd_idx];
        end
      end
    endcase
  end

  // Read data is captured at the address phase and stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // Operand registers are frozen while a conversion runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oper_reg <= '0;
      ctrl_reg <= 16'h0000;
      src_reg <= 32'h0000_0000;
    end else if (wr && idle) begin
      case (ap.addr)
        OFF_OPER: oper_reg <= hwdata[OPER_W-1:0];
        OFF_CTRL: ctrl_reg <= hwdata[15:0];
        OFF_SRC: src_reg <= hwdata;
        default: ;
      endcase
    end
  end

  // Endpoint table, X and Y of each point in adjacent words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < int'(MAX_POINTS); i++) begin
        x_mem[i] <= 32'h0000_0000;
        y_mem[i] <= 32'h0000_0000;
      end
    end else if (wr && idle && ap.addr[TABLE_SEL_BIT] && (32'(ap.addr[10:3]) < MAX_POINTS)) begin
      if (ap.addr[TABLE_Y_BIT]) begin
        y_mem[ap.addr[10:3]] <= hwdata;
      end else begin
        x_mem[ap.addr[10:3]] <= hwdata;
      end
    end
  end

  // Start decode
  assign cw_now = oper_reg[OPER_CONST_C] ? oper_reg[15:0] : ctrl_reg;
  assign cnt_now = cw_now[CNT_MSB:CNT_LSB];

  always_comb begin
    if (cw_now[BIT_IN_BCD]) begin
      s_in = {20'h00000, bcd2bin(src_reg[15:0])};
    end else if (oper_reg[OPER_CONST_S] && cw_now[BIT_SIGNED] && cw_now[BIT_WIDE]) begin
      s_in = {{18{src_reg[15]}}, src_reg[15:0]};
    end else begin
      s_in = norm(src_reg, cw_now);
    end
  end

  // Mirror the source about the largest X
  assign s_eff_now = cw_now[BIT_REVERSE]
    ? norm(x_mem[cnt_now], cw_now) - s_in : s_in;

  // Constant control above cosine; trig source range
  assign trig_bad = (oper_reg[15:0] > CTRL_COSINE) || !bcd_ok(src_reg[15:0])
    || (src_reg[15:0] > TRIG_MAX_BCD);

  // Bad BCD source; constant source with float
  assign start_bad = (cw_now[BIT_IN_BCD] && !bcd_ok(src_reg[15:0]))
    || (cw_now[BIT_FLOAT] && oper_reg[OPER_CONST_S]) || (32'(cnt_now) >= MAX_POINTS);

  // Tenths of a degree in, four truncated BCD digits out
  assign angle_bin = bcd2bin(src_reg[15:0]);
  assign trig_word = {16'h0000, bin2bcd(sine(oper_reg[0]
    ? ANGLE_FULL - angle_bin[9:0] : angle_bin[9:0]))};

  assign xp = norm(x_mem[idx_q - 8'h01], cw_q);
  assign xc = norm(x_mem[idx_q], cw_q);
  assign x0 = norm(x_mem[0], cw_q);
  assign xs = norm(x_mem[seg_q], cw_q);
  assign xs1 = norm(x_mem[seg_q + 8'h01], cw_q);
  assign ys = norm(y_mem[seg_q], cw_q);
  assign ys1 = norm(y_mem[seg_q + 8'h01], cw_q);
  assign yend = norm(y_mem[cw_q[CNT_MSB:CNT_LSB]], cw_q);
  assign dy = ys1 - ys;
  assign rem_sh = {rem_q[32:0], quo_q[33]};
  // Slope quotient truncated toward zero, then signed product
  assign q = qneg_q ? -tls_num_t'(quo_q) : tls_num_t'(quo_q);
  assign interp = ys + q * (s_eff_q - xs);

  always_comb begin
    next_state = state;
    fin = 1'b0;
    fin_err = 1'b0;
    fin_word = result_reg;
    ld_div = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start_go) begin
          if (oper_reg[OPER_CONST_C]) begin
            fin = 1'b1;
            fin_err = trig_bad;
            fin_word = trig_word;
          end else if (start_bad) begin
            fin = 1'b1;
            fin_err = 1'b1;
          end else if (cnt_now == 8'h00) begin
            next_state = ST_PICK;
          end else begin
            next_state = ST_SCAN;
          end
        end
      end
      ST_SCAN: begin
        if (idx_q == cw_q[CNT_MSB:CNT_LSB]) begin
          next_state = ST_PICK;
        end
      end
      ST_PICK: begin
        next_state = ST_IDLE;
        if (order_bad_q) begin
          fin = 1'b1;
          fin_err = 1'b1;
        end else if (s_eff_q < x0) begin
          fin = 1'b1;
          fin_word = fmt(norm(y_mem[0], cw_q), cw_q);
        end else if (hit_q) begin
          fin = 1'b1;
          fin_word = fmt(ys, cw_q);
        end else if (span_q) begin
          ld_div = 1'b1;
          next_state = ST_DIV;
        end else begin
          fin = 1'b1;
          fin_word = fmt(yend, cw_q);
        end
      end
      ST_DIV: begin
        if (dcnt_q == DIV_STEPS) begin
          next_state = ST_MUL;
        end
      end
      ST_MUL: begin
        fin = 1'b1;
        fin_word = fmt(interp, cw_q);
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Segment search, one table step per cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      cw_q <= 16'h0000;
      s_eff_q <= '0;
      idx_q <= 8'h00;
      seg_q <= 8'h00;
      hit_q <= 1'b0;
      span_q <= 1'b0;
      order_bad_q <= 1'b0;
    end else begin
      state <= next_state;
      if (start_go) begin
        cw_q <= cw_now;
        s_eff_q <= s_eff_now;
        idx_q <= 8'h01;
        seg_q <= 8'h00;
        hit_q <= 1'b0;
        span_q <= 1'b0;
        order_bad_q <= 1'b0;
      end else if (state == ST_SCAN) begin
        idx_q <= idx_q + 8'h01;
        if (xc <= xp) begin
          order_bad_q <= 1'b1;
        end
        if (!hit_q && !span_q && (s_eff_q == xp)) begin
          hit_q <= 1'b1;
          seg_q <= idx_q - 8'h01;
        end else if (!hit_q && !span_q && (s_eff_q > xp) && (s_eff_q < xc)) begin
          span_q <= 1'b1;
          seg_q <= idx_q - 8'h01;
        end
      end
    end
  end

  // Restoring divider on magnitudes; the span is always positive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rem_q <= 34'h0;
      quo_q <= 34'h0;
      dvs_q <= 34'h0;
      qneg_q <= 1'b0;
      dcnt_q <= 6'h00;
    end else if (ld_div) begin
      rem_q <= 34'h0;
      quo_q <= dy[33] ? 34'(-dy) : 34'(dy);
      dvs_q <= 34'(xs1 - xs);
      qneg_q <= dy[33];
      dcnt_q <= 6'h00;
    end else if (state == ST_DIV) begin
      dcnt_q <= dcnt_q + 6'h01;
      if (dcnt_q != DIV_STEPS) begin
        if (rem_sh >= dvs_q) begin
          rem_q <= rem_sh - dvs_q;
          quo_q <= {quo_q[32:0], 1'b1};
        end else begin
          rem_q <= rem_sh;
          quo_q <= {quo_q[32:0], 1'b0};
        end
      end
    end
  end

  // Result and flags; an error leaves the previous result in place
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_reg <= RESULT_RST;
      err_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (fin) begin
      // Error set or cleared on every completion
      err_reg <= fin_err;
      done_reg <= 1'b1;
      if (!fin_err) begin
        result_reg <= fin_word;
      end
    end else if (start_go) begin
      done_reg <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** bench/tls_unit_assertions.sv ***
// Port-level checker for the trig and line-segment unit
`timescale 1ns/10ps
`default_nettype none
module tls_unit_assertions
  import tls_pkg::*;
#(
  parameter int unsigned MAX_POINTS = 256
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic busy,
  input wire logic error_flag,
  input wire logic equals_flag,
  input wire logic negative_flag
);
  logic wr_start;
  logic rd_go;
  assign rd_go = hsel && htrans[1] && hready && !hwrite;
  // Marks the data phase of a START write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_start <= 1'b0;
    end else begin
      wr_start <= hsel && htrans[1] && hready && hwrite && haddr[11:0] == OFF_START;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ready; hreadyout == 1'b1 && hresp == 1'b0; endproperty
  a_ready: assert property (p_ready) else $error("bus not ready or not okay");
  property p_start; $rose(busy) |-> $past(wr_start); endproperty
  a_start: assert property (p_start) else $error("busy rose without start");
  property p_len; $rose(busy) |-> ##[1:300] !busy; endproperty
  a_len: assert property (p_len) else $error("conversion too long");
  property p_hold;
    busy ##1 busy |-> $stable({error_flag, equals_flag, negative_flag});
  endproperty
  a_hold: assert property (p_hold) else $error("flags moved while busy");
  property p_stat;
    rd_go && haddr[11:0] == OFF_STATUS |=>
      hrdata[3:0] == $past({negative_flag, equals_flag, error_flag, busy});
  endproperty
  a_stat: assert property (p_stat) else $error("status word mismatch");
  property p_eq;
    rd_go && haddr[11:0] == OFF_RESULT |=> $past(equals_flag) == (hrdata == 32'h0000_0000);
  endproperty
  a_eq: assert property (p_eq) else $error("equals flag wrong");
  property p_neg; rd_go && haddr[11:0] == OFF_RESULT |=> $past(negative_flag) == hrdata[15];
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");
  property p_fin; $fell(busy) |-> !$past(wr_start); endproperty
  a_fin: assert property (p_fin) else $error("finished before start");
endmodule
bind tls_unit tls_unit_assertions #(.MAX_POINTS(MAX_POINTS)) chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .busy(busy),
  .error_flag(error_flag), .equals_flag(equals_flag), .negative_flag(negative_flag));
`default_nettype wire

// *** bench/tls_seq_model.sv ***
// Bus master standing in for the instruction sequencer and its memory
`timescale 1ns/10ps
`default_nettype none
module tls_seq_model
  import tls_pkg::*;
(
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= w;
    // Stale write data is scrambled, never held
    hwdata <= ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= w ? wd : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wpt(input logic [7:0] n, input logic [15:0] x, input logic [15:0] y);
    logic [31:0] r;
    xfer(1'b1, OFF_TABLE | {1'b0, n, 3'b000}, {16'h0000, x}, r);
    xfer(1'b1, OFF_TABLE | {1'b0, n, 3'b100}, {16'h0000, y}, r);
  endtask
endmodule
`default_nettype wire

// *** bench/trig_and_line_segment_unit_test.sv ***
// Register-level tests of the trig and line-segment unit
`timescale 1ns/10ps
`default_nettype none
module trig_and_line_segment_unit_test;
  import tls_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  wire logic hsel;
  wire logic hwrite;
  wire logic hready;
  wire logic hresp;
  wire logic busy;
  wire logic err;
  wire logic eq;
  wire logic neg;
  wire logic [1:0] htrans;
  wire logic [2:0] hsize;
  wire logic [31:0] haddr;
  wire logic [31:0] hwdata;
  wire logic [31:0] hrdata;
  int error_cnt = 0;
  int comparisons = 0;
  int tn = 0;
  logic [31:0] last = 32'h0;
  logic [31:0] r;
  always #20 hclk = ~hclk;
  tls_unit uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .busy(busy), .error_flag(err),
    .equals_flag(eq), .negative_flag(neg));
  tls_seq_model m (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // On error the old result must stay
  task automatic run(input logic [17:0] op, input logic [15:0] c, input logic [15:0] s,
                     input logic [31:0] e, input logic er);
    int i;
    logic [31:0] q;
    m.xfer(1'b1, OFF_OPER, {14'h0000, op}, q);
    m.xfer(1'b1, OFF_CTRL, {16'h0000, c}, q);
    m.xfer(1'b1, OFF_SRC, {16'h0000, s}, q);
    m.xfer(1'b1, OFF_START, 32'h0000_0001, q);
    q = 32'h0;
    for (i = 0; i < 400 && q[ST_DONE] !== 1'b1; i++) begin
      m.xfer(1'b0, OFF_STATUS, 32'h0, q);
    end
    if (er) e = last;
    last = e;
    chk("status", {27'h0, 1'b1, e[15], e == 32'h0, er, 1'b0}, q);
    m.xfer(1'b0, OFF_RESULT, 32'h0, q);
    chk("result", e, q);
    chk("flag pins", {28'h0, 1'b0, er, e == 32'h0, e[15]}, {28'h0, busy, err, eq, neg});
    tn++;
    $display("test %0d ended", tn);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge hclk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    m.xfer(1'b0, OFF_STATUS, 32'h0, r);
    chk("reset status", 32'h0000_0004, r);
    m.xfer(1'b1, OFF_RESULT, 32'h0000_1234, r);
    m.xfer(1'b1, 12'h020, 32'h0000_5678, r);
    m.xfer(1'b0, 12'h020, 32'h0, r);
    chk("unmapped", 32'h0, r);
    m.xfer(1'b0, OFF_RESULT, 32'h0, r);
    chk("read-only result", 32'h0, r);
    run(18'h10000, 16'h0, 16'h0300, 32'h5000, 1'b0);
    run(18'h10001, 16'h0, 16'h0300, 32'h8660, 1'b0);
    run(18'h10000, 16'h0, 16'h0900, 32'h9999, 1'b0);
    run(18'h10001, 16'h0, 16'h0000, 32'h9999, 1'b0);
    run(18'h10000, 16'h0, 16'h0901, 32'h0, 1'b1);
    run(18'h10000, 16'h0, 16'h0A00, 32'h0, 1'b1);
    run(18'h10002, 16'h0, 16'h0300, 32'h0, 1'b1);
    m.wpt(8'd0, 16'h0005, 16'h0F00);
    m.wpt(8'd1, 16'h001A, 16'h0402);
    m.wpt(8'd2, 16'h0030, 16'h0100);
    run(18'h0, 16'h0002, 16'h0014, 32'h0726, 1'b0);
    run(18'h0, 16'h0002, 16'h0002, 32'h0F00, 1'b0);
    run(18'h0, 16'h0002, 16'h0040, 32'h0100, 1'b0);
    run(18'h0, 16'h0002, 16'h001A, 32'h0402, 1'b0);
    run(18'h0, 16'h2002, 16'h001C, 32'h0726, 1'b0);
    run(18'h0, 16'h8002, 16'h0020, 32'h0726, 1'b0);
    run(18'h0, 16'h4002, 16'h0014, 32'h1830, 1'b0);
    run(18'h0, 16'h8002, 16'h001A, 32'h0, 1'b1);
    run(18'h0, 16'h0802, 16'hFFF0, 32'h0F00, 1'b0);
    run(18'h20000, 16'h0C02, 16'hFFFF, 32'h0F00, 1'b0);
    run(18'h20000, 16'h0202, 16'h0014, 32'h0, 1'b1);
    m.wpt(8'd0, 16'h0005, 16'h9000);
    run(18'h0, 16'h0002, 16'h0001, 32'h9000, 1'b0);
    m.wpt(8'd2, 16'h001A, 16'h0100);
    run(18'h0, 16'h0002, 16'h0014, 32'h0, 1'b1);
    m.xfer(1'b1, OFF_TABLE, 32'h3F80_0000, r);
    m.xfer(1'b1, OFF_TABLE | 12'h004, 32'h4000_0000, r);
    m.xfer(1'b1, OFF_TABLE | 12'h008, 32'h4040_0000, r);
    run(18'h0, 16'h0201, 16'h0000, 32'h4000_0000, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
